// *** pkg/qcp_pkg.sv ***
// Package for the quiet chopper PWM configuration block
package qcp_pkg;
  // Register indices (plain port address)
  localparam logic [3:0] ADDR_GRAD = 4'h0;
  localparam logic [3:0] ADDR_OFS = 4'h1;
  localparam logic [3:0] ADDR_CHOP = 4'h2;
  localparam logic [3:0] ADDR_AUTO_SCALE = 4'h3;
  localparam logic [3:0] ADDR_AUTO_GRAD = 4'h4;
  localparam logic [3:0] ADDR_AUTO_OFS = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  // Field positions in the chopper control word
  localparam int OFF_TIME_LSB = 0;
  localparam int BLANK_LSB = 4;
  localparam int STANDSTILL_LSB = 6;
  localparam int QUIET_EN_BIT = 8;
  localparam int HOLD_LSB = 9;
  // Reset values
  localparam logic [7:0] GRAD_RST = 8'h00;
  localparam logic [7:0] OFS_RST = 8'h00;
  localparam logic [3:0] OFF_TIME_RST = 4'h0;
  localparam logic [1:0] BLANK_RST = 2'h0;
  // Blank times in clock periods per setting
  localparam logic [5:0] BLANK_CYC0 = 6'h10;
  localparam logic [5:0] BLANK_CYC1 = 6'h18;
  localparam logic [5:0] BLANK_CYC2 = 6'h24;
  localparam logic [5:0] BLANK_CYC3 = 6'h36;
  // Standstill options
  localparam logic [1:0] SS_NORMAL = 2'h0;
  localparam logic [1:0] SS_STANDSTILL_OPTION = 2'h1;
  localparam logic [1:0] SS_SHORT_LS = 2'h2;
  localparam logic [1:0] SS_SHORT_HS = 2'h3;
  localparam logic [8:0] SCALE_MAX = 9'h0FF;
  localparam logic [8:0] SCALE_MIN = 9'h101;

  typedef struct packed {
    logic [7:0] grad;
    logic [7:0] ofs;
    logic [3:0] off_time;
    logic [1:0] blank_sel;
    logic [1:0] standstill;
    logic quiet_en;
    logic [4:0] hold_cur;
  } qcp_cfg_t;

  typedef struct packed {
    logic lin_scale_en;
    logic drv_en;
    logic standstill_option;
    logic brake_ls;
    logic brake_hs;
    logic blank_active;
  } qcp_drv_t;

  typedef enum logic [0:0] {BL_IDLE, BL_RUN} qcp_blank_st_t;

  typedef struct packed {
    qcp_cfg_t cfg;
    logic signed [8:0] scale;
    logic [7:0] auto_grad;
    logic [7:0] auto_ofs;
    logic [1:0] sw_sync;
    logic sw_last;
    qcp_blank_st_t bst;
    logic [5:0] bcnt;
    qcp_drv_t drv;
    logic [15:0] rdata;
  } qcp_state_t;
endpackage

// *** design/qcp_chopper_cfg.sv ***
// Quiet chopper PWM configuration, read-back and comparator blanking
// What this block does
// - Accept gradient 0..255, seed gradient tuning while tuning is idle
// - Accept offset 0..255, zero stops linear scaling
// - Standstill option only at zero hold, quiet
// - Signed scaling read-back, frozen in cycle mode
// - Read-only tuned gradient 0..255
// - Off-time zero switches driver off
// - Blank comparator 16..54 clocks after switching
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module qcp_chopper_cfg (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Regulator side
  input wire logic cycle_mode,
  input wire logic scale_upd,
  input wire logic signed [8:0] scale_in,
  input wire logic tune_upd,
  input wire logic [7:0] tune_grad_in,
  input wire logic [7:0] tune_ofs_in,
  input wire logic switch_evt,
  // Configuration and driver outputs
  output qcp_pkg::qcp_cfg_t cfg,
  output qcp_pkg::qcp_drv_t drv
);
  qcp_pkg::qcp_state_t s_reg, s_next;
  logic [5:0] blank_len;
  logic sw_edge;
  logic signed [8:0] sc_clip;
  // Helpers computed from registered state and the port only
  logic wr_grad;
  logic wr_ofs;
  logic wr_chop;
  logic [15:0] rd_word;
  qcp_pkg::qcp_blank_st_t bst_n;
  logic [5:0] bcnt_n;

  // Control word layout, shared by the write path and the read-back
  function automatic logic [15:0] chop_pack(input qcp_pkg::qcp_cfg_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[qcp_pkg::OFF_TIME_LSB +: 4] = c.off_time;
    w[qcp_pkg::BLANK_LSB +: 2] = c.blank_sel;
    w[qcp_pkg::STANDSTILL_LSB +: 2] = c.standstill;
    w[qcp_pkg::QUIET_EN_BIT] = c.quiet_en;
    w[qcp_pkg::HOLD_LSB +: 5] = c.hold_cur;
    return w;
  endfunction

  // Unpack a control word; gradient and offset are left as they were
  function automatic qcp_pkg::qcp_cfg_t chop_unpack(
    input qcp_pkg::qcp_cfg_t old_cfg,
    input logic [15:0] w
  );
    qcp_pkg::qcp_cfg_t c;
    c = old_cfg;
    c.off_time = w[qcp_pkg::OFF_TIME_LSB +: 4];
    c.blank_sel = w[qcp_pkg::BLANK_LSB +: 2];
    c.standstill = w[qcp_pkg::STANDSTILL_LSB +: 2];
    c.quiet_en = w[qcp_pkg::QUIET_EN_BIT];
    c.hold_cur = w[qcp_pkg::HOLD_LSB +: 5];
    return c;
  endfunction

  // Write decode; read-only and unmapped indices are ignored
  always_comb begin
    wr_grad = 1'b0;
    wr_ofs = 1'b0;
    wr_chop = 1'b0;
    if (wr) begin
      case (addr)
        qcp_pkg::ADDR_GRAD: wr_grad = 1'b1;
        qcp_pkg::ADDR_OFS: wr_ofs = 1'b1;
        qcp_pkg::ADDR_CHOP: wr_chop = 1'b1;
        default: wr_chop = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (s_reg.cfg.blank_sel)
      2'h0: blank_len = qcp_pkg::BLANK_CYC0;
      2'h1: blank_len = qcp_pkg::BLANK_CYC1;
      2'h2: blank_len = qcp_pkg::BLANK_CYC2;
      default: blank_len = qcp_pkg::BLANK_CYC3;
    endcase
  end

  // Switch event arrives from the power stage, so it is synchronised
  assign sw_edge = s_reg.sw_sync[1] & ~s_reg.sw_last;

  always_comb begin
    if (scale_in > $signed(qcp_pkg::SCALE_MAX)) begin
      sc_clip = $signed(qcp_pkg::SCALE_MAX);
    end else if (scale_in < $signed(qcp_pkg::SCALE_MIN)) begin
      sc_clip = $signed(qcp_pkg::SCALE_MIN);
    end else begin
      sc_clip = scale_in;
    end
  end

  // blank timer restarts on every switching edge
  always_comb begin
    bst_n = s_reg.bst;
    bcnt_n = s_reg.bcnt;
    case (s_reg.bst)
      qcp_pkg::BL_IDLE: begin
        if (sw_edge) begin
          bst_n = qcp_pkg::BL_RUN;
          bcnt_n = blank_len - 6'h01;
        end
      end
      qcp_pkg::BL_RUN: begin
        if (sw_edge) begin
          bcnt_n = blank_len - 6'h01;
        end else if (s_reg.bcnt == 6'h00) begin
          bst_n = qcp_pkg::BL_IDLE;
        end else begin
          bcnt_n = s_reg.bcnt - 6'h01;
        end
      end
      default: bst_n = qcp_pkg::BL_IDLE;
    endcase
  end

  // Read mux sees only registered state; rdata follows rd by one cycle
  always_comb begin
    case (addr)
      qcp_pkg::ADDR_GRAD: rd_word = {8'h00, s_reg.cfg.grad};
      qcp_pkg::ADDR_OFS: rd_word = {8'h00, s_reg.cfg.ofs};
      qcp_pkg::ADDR_CHOP: rd_word = chop_pack(s_reg.cfg);
      qcp_pkg::ADDR_AUTO_SCALE:
        rd_word = {{7{s_reg.scale[8]}}, s_reg.scale};
      qcp_pkg::ADDR_AUTO_GRAD: rd_word = {8'h00, s_reg.auto_grad};
      qcp_pkg::ADDR_AUTO_OFS: rd_word = {8'h00, s_reg.auto_ofs};
      qcp_pkg::ADDR_STATUS: rd_word = {10'h000, s_reg.drv};
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    // Only the second stage is read; the first may still be settling
    s_next.sw_sync = {s_reg.sw_sync[0], switch_evt};
    s_next.sw_last = s_reg.sw_sync[1];
    s_next.rdata = 16'h0000;
    if (wr_grad) begin
      s_next.cfg.grad = wdata[7:0];
    end
    if (wr_ofs) begin
      s_next.cfg.ofs = wdata[7:0];
    end
    if (wr_chop) begin
      s_next.cfg = chop_unpack(s_next.cfg, wdata);
    end
    if (scale_upd && !cycle_mode) begin
      s_next.scale = sc_clip;
    end
    // tuner results; user values seed it while tuning is idle
    if (tune_upd) begin
      s_next.auto_grad = tune_grad_in;
      s_next.auto_ofs = tune_ofs_in;
    end else if (wr_grad) begin
      s_next.auto_grad = wdata[7:0];
    end else if (wr_ofs) begin
      s_next.auto_ofs = wdata[7:0];
    end
    // blanking flag follows the timer state
    s_next.bst = bst_n;
    s_next.bcnt = bcnt_n;
    s_next.drv.blank_active = (bst_n == qcp_pkg::BL_RUN);
    s_next.drv.drv_en = (s_next.cfg.off_time != 4'h0);
    // zero offset turns linear current scaling off
    s_next.drv.lin_scale_en = (s_next.cfg.ofs != 8'h00);
    s_next.drv.standstill_option = 1'b0;
    s_next.drv.brake_ls = 1'b0;
    s_next.drv.brake_hs = 1'b0;
    // standstill only at zero hold with quiet mode
    if (s_next.cfg.hold_cur == 5'h00 && s_next.cfg.quiet_en) begin
      case (s_next.cfg.standstill)
        qcp_pkg::SS_STANDSTILL_OPTION: s_next.drv.standstill_option = 1'b1;
        qcp_pkg::SS_SHORT_LS: s_next.drv.brake_ls = 1'b1;
        qcp_pkg::SS_SHORT_HS: s_next.drv.brake_hs = 1'b1;
        default: s_next.drv.standstill_option = 1'b0;
      endcase
    end
    if (rd) begin
      s_next.rdata = rd_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{cfg: '{grad: qcp_pkg::GRAD_RST, ofs: qcp_pkg::OFS_RST,
        off_time: qcp_pkg::OFF_TIME_RST, blank_sel: qcp_pkg::BLANK_RST,
        standstill: qcp_pkg::SS_NORMAL, quiet_en: 1'b0, hold_cur: 5'h00},
        scale: 9'h000, auto_grad: qcp_pkg::GRAD_RST,
        auto_ofs: qcp_pkg::OFS_RST, sw_sync: 2'h0, sw_last: 1'b0,
        bst: qcp_pkg::BL_IDLE, bcnt: 6'h00, drv: '0, rdata: 16'h0000};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign cfg = s_reg.cfg;
  assign drv = s_reg.drv;
endmodule
`default_nettype wire

// *** bench/qcp_monitor.sv ***
// Assertion checker for the quiet chopper configuration block
`timescale 1ns/1ps
`default_nettype none
module qcp_monitor (
  // Clock and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Watched signals
  input wire logic switch_evt,
  input wire qcp_pkg::qcp_cfg_t cfg,
  input wire qcp_pkg::qcp_drv_t drv
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sw_rise;
    $rose(switch_evt);
  endsequence
  drv_enable_a: assert property (drv.drv_en == (cfg.off_time != 4'h0))
    else $error("driver enable wrong");
  grad_write_a: assert property (wr && addr == qcp_pkg::ADDR_GRAD
    |=> cfg.grad == $past(wdata[7:0])) else $error("gradient not taken");
  ofs_write_a: assert property (wr && addr == qcp_pkg::ADDR_OFS
    |=> cfg.ofs == $past(wdata[7:0])) else $error("offset not taken");
  lin_scale_a: assert property (wr && addr == qcp_pkg::ADDR_OFS
    |=> drv.lin_scale_en == ($past(wdata[7:0]) != 8'h00))
    else $error("linear scaling flag wrong");
  grad_read_a: assert property (rd && addr == qcp_pkg::ADDR_GRAD
    |=> rdata == {8'h00, $past(cfg.grad)}) else $error("gradient read");
  hold_gate_a: assert property (drv.standstill_option || drv.brake_ls ||
    drv.brake_hs |-> cfg.hold_cur == 5'h00 && cfg.quiet_en)
    else $error("standstill option without zero hold");
  scale_range_a: assert property (rd && addr == qcp_pkg::ADDR_AUTO_SCALE
    |=> rdata[8:0] != 9'h100) else $error("scale out of range");
  blank_start_a: assert property (sw_rise |-> ##[3:4] drv.blank_active)
    else $error("blanking did not start");
  blank_min_a: assert property (sw_rise ##4 drv.blank_active
    |-> drv.blank_active[*8]) else $error("blanking too short");
endmodule
bind qcp_chopper_cfg qcp_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .switch_evt(switch_evt), .cfg(cfg), .drv(drv));
`default_nettype wire

// *** bench/qcp_host.sv ***
// Host model that sets up the block over the register port
`timescale 1ns/1ps
`default_nettype none
module qcp_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [3:0] addr = 4'h0,
  output logic [15:0] wdata = 16'h0000,
  output logic wr = 1'b0,
  output logic rd = 1'b0
);
  // One strobe cycle, then a quiet cycle so strobes never double-assign
  task automatic access(input logic w, input logic [3:0] a,
                        input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the quiet chopper configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, seen = 1'b0, cyc = 1'b0, s_up = 1'b0;
  logic t_up = 1'b0, sw = 1'b0, wr, rd;
  logic signed [8:0] s_in = 9'h000;
  logic [7:0] tg = 8'h00, v;
  logic [3:0] addr;
  logic [4:0] h;
  logic [1:0] ss;
  logic q;
  logic [15:0] wdata, rdata, e, exp_q[$];
  int err_count = 0, n_tests = 0, len, blen[4] = '{16, 24, 36, 54};
  qcp_pkg::qcp_cfg_t cfg;
  qcp_pkg::qcp_drv_t drv;
  always #2.5 clk = ~clk;
  qcp_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  qcp_chopper_cfg DUT (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cycle_mode(cyc),
    .scale_upd(s_up), .scale_in(s_in), .tune_upd(t_up), .tune_grad_in(tg),
    .tune_ofs_in(~tg), .switch_evt(sw), .cfg(cfg), .drv(drv));
  task automatic check(input string what, input logic [15:0] got, x);
    n_tests++;
    if (got !== x) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, x, got);
    end
  endtask
  task automatic rd_exp(input logic [3:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    host.access(1'b0, a, 16'h0000);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) seen <= rd;
  always @(negedge clk) if (seen) check("rdata", rdata, exp_q.pop_front());
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h567d));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      host.access(1'b1, qcp_pkg::ADDR_GRAD, {8'h00, v});
      host.access(1'b1, qcp_pkg::ADDR_OFS, {8'h00, ~v});
      rd_exp(qcp_pkg::ADDR_GRAD, {8'h00, v});
      rd_exp(qcp_pkg::ADDR_AUTO_GRAD, {8'h00, v});
      rd_exp(qcp_pkg::ADDR_OFS, {8'h00, ~v});
      rd_exp(qcp_pkg::ADDR_STATUS, {10'h000, ~v != 8'h00, 5'h00});
    end
    // Pass 4 holds current; pass 5 leaves quiet mode, driver off
    for (int i = 0; i < 6; i++) begin
      h = (i == 4) ? 5'h01 : 5'h00;
      q = (i != 5);
      ss = (i > 3) ? 2'h1 : 2'(i);
      e = {2'b00, h, q, ss, ss, (i == 5) ? 4'h0 : 4'h1};
      host.access(1'b1, qcp_pkg::ADDR_CHOP, e);
      rd_exp(qcp_pkg::ADDR_CHOP, e);
      rd_exp(qcp_pkg::ADDR_STATUS, {10'h000, v != 8'hFF, i != 5,
        q && h == 0 && ss == 1, q && h == 0 && ss == 2,
        q && h == 0 && ss == 3, 1'b0});
    end
    for (int i = 0; i < 4; i++) begin
      host.access(1'b1, qcp_pkg::ADDR_CHOP, {10'h000, 2'(i), 4'h1});
      sw <= 1'b1;
      len = 0;
      repeat (3) @(posedge clk);
      sw <= 1'b0;
      repeat (70) @(negedge clk) len += int'(drv.blank_active);
      check("blank", 16'(len), 16'(blen[i]));
    end
    @(posedge clk);
    s_in <= 9'h100;
    s_up <= 1'b1;
    tg <= 8'($urandom);
    t_up <= 1'b1;
    @(posedge clk);
    s_in <= 9'h005;
    t_up <= 1'b0;
    cyc <= 1'b1;
    @(posedge clk);
    s_up <= 1'b0;
    rd_exp(qcp_pkg::ADDR_AUTO_SCALE, 16'hFF01);
    host.access(1'b1, qcp_pkg::ADDR_AUTO_GRAD, {8'h00, ~tg});
    rd_exp(qcp_pkg::ADDR_AUTO_GRAD, {8'h00, tg});
    rd_exp(qcp_pkg::ADDR_AUTO_OFS, {8'h00, ~tg});
    rd_exp(4'hF, 16'h0000);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
